// File: pkg/skl_pkg.sv
// Constants shared by the key and lifecycle controller.
package skl_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [15:0] SKL_OFF_ENABLE = 16'h0500;
   localparam logic [15:0] SKL_OFF_LIFECYCLE = 16'h1A00;
   localparam logic [15:0] SKL_OFF_ROOT_KEY0 = 16'h1A10;
   localparam logic [15:0] SKL_OFF_FIXED_LOCK = 16'h1A20;
   localparam logic [15:0] SKL_OFF_KEY_SELECT = 16'h1A38;
   localparam logic [15:0] SKL_OFF_SESSION_KEY0 = 16'h1A40;
   localparam logic [15:0] SKL_WORD_STRIDE = 16'h0004;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int SKL_LC_WIDTH = 4;
   localparam int SKL_LC_VALID_BIT = 8;
   localparam int SKL_KEY_WIDTH = 128;
   localparam int SKL_KEY_WORDS = 4;
   localparam int SKL_SEL_WIDTH = 2;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [3:0] SKL_LC_DEBUG = 4'h0;
   localparam logic [3:0] SKL_LC_SECURE = 4'h2;
   localparam logic [1:0] SKL_SEL_FIXED = 2'h0;
   localparam logic [1:0] SKL_SEL_ROOT = 2'h1;
   localparam logic [1:0] SKL_SEL_SESSION = 2'h2;
   localparam logic [1:0] SKL_HTRANS_NONSEQ = 2'h2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] SKL_LC_RESET = SKL_LC_SECURE;
   localparam logic [1:0] SKL_SEL_RESET = SKL_SEL_FIXED;

   // The fixed key value is arbitrary.
   localparam logic [127:0] SKL_FIXED_KEY = 128'h5A5A_C3C3_0F0F_9696_A5A5_3C3C_F0F0_6969;

endpackage : skl_pkg

// File: src/skl_ctrl.sv
// Key selection and lifecycle controller with an AHB-Lite register slave.
`timescale 1ns/1ps

module skl_ctrl (
   // Clock, reset and clock enable
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic CE,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [15:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   // Subsystem status and key toward the cipher engine
   output logic SUBSYS_ENABLE,
   output logic IDLE_BLOCK,
   output logic [skl_pkg::SKL_KEY_WIDTH-1:0] AES_KEY
);
   import skl_pkg::*;

   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic wr_pend_r;
   logic [15:0] addr_r;
   logic addr_ok;
   logic wr_hit;

   // Only whole-word accesses are decoded; others complete with no effect.
   assign addr_ok = HSEL && HREADY && (HTRANS == SKL_HTRANS_NONSEQ) && (HSIZE == 3'h2);
   assign wr_hit = CE && wr_pend_r;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         wr_pend_r <= 1'b0;
         addr_r <= 16'h0000;
      end else if (CE) begin
         wr_pend_r <= addr_ok && HWRITE;
         if (addr_ok) begin
            addr_r <= HADDR;
         end
      end
   end

   // ----------------------------------------------------------------
   // Word decode of the data phase address
   // ----------------------------------------------------------------
   logic [SKL_KEY_WORDS-1:0] root_word_hit;
   logic [SKL_KEY_WORDS-1:0] sess_word_hit;
   logic lc_write_legal;

   always_comb begin
      for (int i = 0; i < SKL_KEY_WORDS; i++) begin
         root_word_hit[i] = wr_hit &&
            (addr_r == SKL_OFF_ROOT_KEY0 + 16'(i) * SKL_WORD_STRIDE);
         sess_word_hit[i] = wr_hit &&
            (addr_r == SKL_OFF_SESSION_KEY0 + 16'(i) * SKL_WORD_STRIDE);
      end
   end

   assign lc_write_legal = wr_hit && (addr_r == SKL_OFF_LIFECYCLE) &&
      ((HWDATA[SKL_LC_WIDTH-1:0] == SKL_LC_DEBUG) ||
       (HWDATA[SKL_LC_WIDTH-1:0] == SKL_LC_SECURE));

   // ----------------------------------------------------------------
   // Subsystem enable
   // ----------------------------------------------------------------
   logic enable_r;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         enable_r <= 1'b0;
      end else if (wr_hit && (addr_r == SKL_OFF_ENABLE)) begin
         enable_r <= HWDATA[0];
      end
   end

   // ----------------------------------------------------------------
   // Retention domain: lifecycle, fixed key lock and root key
   // ----------------------------------------------------------------
   // These flops are not touched by the enable, so they keep their content
   // while the subsystem is disabled; only reset clears them.
   logic [SKL_LC_WIDTH-1:0] lc_state_r;
   logic lc_valid_r;
   logic fixed_locked_r;
   logic [SKL_KEY_WIDTH-1:0] root_key_r;
   logic [SKL_KEY_WORDS-1:0] root_written_r;
   logic root_captured;

   assign root_captured = &root_written_r;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         lc_state_r <= SKL_LC_RESET;
         lc_valid_r <= 1'b0;
      end else if (lc_write_legal) begin
         lc_state_r <= HWDATA[SKL_LC_WIDTH-1:0];
         lc_valid_r <= 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         fixed_locked_r <= 1'b0;
      end else if (wr_hit && (addr_r == SKL_OFF_FIXED_LOCK) && HWDATA[0]) begin
         fixed_locked_r <= 1'b1;
      end
   end

   // A word is taken only with a valid lifecycle: any number of times in
   // debug, once per reset in secure.
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         root_key_r <= '0;
         root_written_r <= '0;
      end else begin
         for (int i = 0; i < SKL_KEY_WORDS; i++) begin
            if (root_word_hit[i] && lc_valid_r &&
                ((lc_state_r == SKL_LC_DEBUG) || !root_written_r[i])) begin
               root_key_r[i*32 +: 32] <= HWDATA;
               root_written_r[i] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Key selection and session key
   // ----------------------------------------------------------------
   logic [SKL_SEL_WIDTH-1:0] key_sel_r;
   logic [SKL_KEY_WIDTH-1:0] session_key_r;
   logic [SKL_KEY_WIDTH-1:0] key_nxt;

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         key_sel_r <= SKL_SEL_RESET;
      end else if (wr_hit && (addr_r == SKL_OFF_KEY_SELECT)) begin
         key_sel_r <= HWDATA[SKL_SEL_WIDTH-1:0];
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         session_key_r <= '0;
      end else begin
         for (int i = 0; i < SKL_KEY_WORDS; i++) begin
            if (sess_word_hit[i]) begin
               session_key_r[i*32 +: 32] <= HWDATA;
            end
         end
      end
   end

   always_comb begin
      key_nxt = '0;
      case (key_sel_r)
         SKL_SEL_FIXED: key_nxt = fixed_locked_r ? '0 : SKL_FIXED_KEY;
         SKL_SEL_ROOT: key_nxt = root_key_r;
         SKL_SEL_SESSION: key_nxt = session_key_r;
         default: key_nxt = '0;
      endcase
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   logic [31:0] rdata_nxt;

   // Root key and session key words are write-only; word 0 of the root
   // key reports capture instead of content.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (HADDR)
         SKL_OFF_ENABLE: rdata_nxt = {31'h0, enable_r};
         SKL_OFF_LIFECYCLE: rdata_nxt = {23'h0, lc_valid_r, 4'h0, lc_state_r};
         SKL_OFF_ROOT_KEY0: rdata_nxt = {31'h0, root_captured};
         SKL_OFF_FIXED_LOCK: rdata_nxt = {31'h0, fixed_locked_r};
         SKL_OFF_KEY_SELECT: rdata_nxt = {30'h0, key_sel_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         HRDATA <= 32'h0000_0000;
      end else if (CE && addr_ok && !HWRITE) begin
         HRDATA <= rdata_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         AES_KEY <= '0;
      end else if (CE) begin
         AES_KEY <= key_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         SUBSYS_ENABLE <= 1'b0;
         IDLE_BLOCK <= 1'b0;
      end else if (CE) begin
         SUBSYS_ENABLE <= enable_r;
         IDLE_BLOCK <= enable_r;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   a_reset_clears: assert property (disable iff (1'b0)
      RESET |=> (lc_state_r == SKL_LC_SECURE) && !lc_valid_r && !fixed_locked_r &&
         (root_key_r == '0) && (root_written_r == '0))
      else $error("Reset left retained content.");

   a_lock_sticky: assert property (
      fixed_locked_r |=> fixed_locked_r)
      else $error("Fixed key lock released without reset.");

   a_zero_key: assert property (
      CE && (key_sel_r == SKL_SEL_FIXED) && fixed_locked_r |=> AES_KEY == '0)
      else $error("Locked fixed key was routed.");

   a_root_route: assert property (
      CE && (key_sel_r == SKL_SEL_ROOT) |=> AES_KEY == $past(root_key_r))
      else $error("Root key not routed one cycle later.");

   a_valid_cause: assert property (
      $rose(lc_valid_r) |-> $past(lc_write_legal))
      else $error("Lifecycle valid rose without legal write.");

   a_secure_once: assert property (
      root_word_hit[0] && lc_valid_r && (lc_state_r == SKL_LC_SECURE) && root_written_r[0]
      |=> root_key_r[31:0] == $past(root_key_r[31:0]))
      else $error("Secure root key word rewritten.");

   a_debug_rewrite: assert property (
      root_word_hit[0] && lc_valid_r && (lc_state_r == SKL_LC_DEBUG)
      |=> root_key_r[31:0] == $past(HWDATA))
      else $error("Debug root key write lost.");

   a_capture_read: assert property (
      CE && addr_ok && !HWRITE && (HADDR == SKL_OFF_ROOT_KEY0)
      |=> HRDATA == {31'h0, $past(root_captured)})
      else $error("Root key word 0 read wrong capture state.");

   a_enable_idle: assert property (
      wr_hit && (addr_r == SKL_OFF_ENABLE) ##1 CE |=> IDLE_BLOCK == $past(HWDATA[0], 2))
      else $error("Idle block does not follow enable.");

endmodule // skl_ctrl

// File: test/skl_ctrl_test.sv
// Self-checking testbench for the key and lifecycle controller.
`timescale 1ns/1ps

module skl_ctrl_test;
   import skl_pkg::*;

   // ----------------------------------------------------------------
   // Bench signals and reference model state
   // ----------------------------------------------------------------
   logic clock, reset, ce, hsel, hwrite, hreadyout, hresp, subsys_enable, idle_block;
   logic [15:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, r;
   logic [127:0] aes_key;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   logic [3:0] m_lc;
   logic [1:0] m_sel;
   bit m_valid, m_lock, m_en;
   logic [31:0] m_root [4];
   logic [31:0] m_sess [4];
   bit m_done [4];

   skl_ctrl DUT (.CLOCK(clock), .RESET(reset), .CE(ce), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .SUBSYS_ENABLE(subsys_enable),
      .IDLE_BLOCK(idle_block), .AES_KEY(aes_key));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // A hung handshake is cut short here.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // Checking and model
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [127:0] m_key();
      case (m_sel)
         SKL_SEL_FIXED: return m_lock ? 128'h0 : SKL_FIXED_KEY;
         SKL_SEL_ROOT: return {m_root[3], m_root[2], m_root[1], m_root[0]};
         SKL_SEL_SESSION: return {m_sess[3], m_sess[2], m_sess[1], m_sess[0]};
         default: return 128'h0;
      endcase
   endfunction

   function automatic logic [31:0] m_read(input logic [15:0] a);
      case (a)
         SKL_OFF_ENABLE: return {31'h0, m_en};
         SKL_OFF_LIFECYCLE: return {23'h0, m_valid, 4'h0, m_lc};
         SKL_OFF_ROOT_KEY0: return {31'h0, m_done[0] & m_done[1] & m_done[2] & m_done[3]};
         SKL_OFF_FIXED_LOCK: return {31'h0, m_lock};
         SKL_OFF_KEY_SELECT: return {30'h0, m_sel};
         default: return 32'h0;
      endcase
   endfunction

   task automatic m_write(input logic [15:0] a, input logic [31:0] d);
      int i;
      // A frozen block takes no write at all.
      if (ce !== 1'b1) return;
      i = int'(a[3:2]);
      if (a == SKL_OFF_ENABLE) m_en = d[0];
      if (a == SKL_OFF_FIXED_LOCK) m_lock = m_lock | d[0];
      if (a == SKL_OFF_KEY_SELECT) m_sel = d[1:0];
      if (a == SKL_OFF_LIFECYCLE && (d[3:0] == SKL_LC_DEBUG || d[3:0] == SKL_LC_SECURE)) begin
         m_lc = d[3:0];
         m_valid = 1'b1;
      end
      if (a[15:4] == SKL_OFF_ROOT_KEY0[15:4] && m_valid
          && !(m_lc == SKL_LC_SECURE && m_done[i])) begin
         m_root[i] = d;
         m_done[i] = 1'b1;
      end
      if (a[15:4] == SKL_OFF_SESSION_KEY0[15:4]) m_sess[i] = d;
   endtask

   task automatic m_reset();
      m_lc = SKL_LC_RESET;
      m_sel = SKL_SEL_RESET;
      m_valid = 1'b0;
      m_lock = 1'b0;
      m_en = 1'b0;
      for (int i = 0; i < 4; i++) begin
         m_root[i] = 32'h0;
         m_sess[i] = 32'h0;
         m_done[i] = 1'b0;
      end
   endtask

   // ----------------------------------------------------------------
   // Bus master and stimulus helpers
   // ----------------------------------------------------------------
   task automatic wait_rdy();
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
   endtask

   task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= SKL_HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= 3'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      chk({127'h0, hresp}, 128'h0, "response");
      if (w) m_write(a, d);
      else chk({96'h0, hrdata}, {96'h0, m_read(a)}, "read");
   endtask

   task automatic outs();
      repeat (2) @(posedge clock);
      #1;
      chk(aes_key, m_key(), "key");
      chk({127'h0, subsys_enable}, {127'h0, m_en}, "enable");
      chk({127'h0, idle_block}, {127'h0, m_en}, "idle block");
      @(posedge clock);
   endtask

   task automatic words(input logic [15:0] base);
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         xfer(base + 16'(i * 4), 1'b1, r);
      end
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 16'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      void'($urandom(32'h2F64967A));
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      m_reset();
      outs();
      xfer(SKL_OFF_LIFECYCLE, 1'b0, 32'h0);
      xfer(SKL_OFF_ENABLE, 1'b1, 32'h1);
      outs();
      words(SKL_OFF_ROOT_KEY0);
      xfer(SKL_OFF_ROOT_KEY0, 1'b0, 32'h0);
      xfer(SKL_OFF_LIFECYCLE, 1'b1, 32'h5);
      xfer(SKL_OFF_LIFECYCLE, 1'b0, 32'h0);
      xfer(SKL_OFF_LIFECYCLE, 1'b1, {28'h0, SKL_LC_DEBUG});
      xfer(SKL_OFF_LIFECYCLE, 1'b0, 32'h0);
      words(SKL_OFF_ROOT_KEY0);
      xfer(SKL_OFF_ROOT_KEY0, 1'b0, 32'h0);
      xfer(SKL_OFF_KEY_SELECT, 1'b1, {30'h0, SKL_SEL_ROOT});
      outs();
      words(SKL_OFF_ROOT_KEY0);
      outs();
      for (int i = 1; i < 4; i++) xfer(SKL_OFF_ROOT_KEY0 + 16'(i * 4), 1'b0, 32'h0);
      xfer(16'h0100, 1'b1, $urandom);
      xfer(16'h0100, 1'b0, 32'h0);
      xfer(SKL_OFF_ENABLE, 1'b1, 32'h0);
      outs();
      words(SKL_OFF_SESSION_KEY0);
      for (int i = 0; i < 8; i++) begin
         xfer(SKL_OFF_KEY_SELECT, 1'b1, $urandom & 32'h3);
         outs();
      end
      xfer(SKL_OFF_KEY_SELECT, 1'b1, {30'h0, SKL_SEL_FIXED});
      xfer(SKL_OFF_FIXED_LOCK, 1'b1, 32'h0);
      outs();
      xfer(SKL_OFF_FIXED_LOCK, 1'b1, 32'h1);
      outs();
      xfer(SKL_OFF_FIXED_LOCK, 1'b1, 32'h0);
      xfer(SKL_OFF_FIXED_LOCK, 1'b0, 32'h0);
      // With the clock enable low a key select write must be lost.
      ce <= 1'b0;
      xfer(SKL_OFF_KEY_SELECT, 1'b1, {30'h0, SKL_SEL_ROOT});
      outs();
      ce <= 1'b1;
      xfer(SKL_OFF_KEY_SELECT, 1'b0, 32'h0);
      outs();
      reset <= 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      m_reset();
      outs();
      xfer(SKL_OFF_LIFECYCLE, 1'b0, 32'h0);
      xfer(SKL_OFF_ROOT_KEY0, 1'b0, 32'h0);
      xfer(SKL_OFF_LIFECYCLE, 1'b1, {28'h0, SKL_LC_SECURE});
      xfer(SKL_OFF_LIFECYCLE, 1'b0, 32'h0);
      words(SKL_OFF_ROOT_KEY0);
      xfer(SKL_OFF_KEY_SELECT, 1'b1, {30'h0, SKL_SEL_ROOT});
      outs();
      words(SKL_OFF_ROOT_KEY0);
      outs();
      final_report();
   end

endmodule // skl_ctrl_test
